/* logic/vlt_ctrl.v */
// VID link target control: link receiver, reference ramp, PWM limiter, APB registers
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "vlt_regs.vh"
module vlt_ctrl (
  input  wire        pclk,              // System clock, 125 MHz
  input  wire        presetn,           // Asynchronous reset, active low
  input  wire        psel,              // APB select
  input  wire        penable,           // APB access phase
  input  wire        pwrite,            // APB write
  input  wire [11:0] paddr,             // APB byte address
  input  wire [31:0] pwdata,            // APB write data
  output reg  [31:0] prdata,            // APB read data
  output reg         pready,            // APB ready
  output reg         pslverr,           // APB error on unmapped address
  input  wire        link_clk,          // Link clock from host
  input  wire        link_data,         // Link data from host
  output reg         alert_n,           // Link alert to host, active low
  output reg  [7:0]  vid_ref,           // Ramping reference VID code
  output reg  [1:0]  power_state,       // Current power state
  output reg         cycle_blank_pulse, // Blank pulse at switching cycle start
  output reg         high_side_switch,  // High-side gate drive
  output reg         low_side_switch    // Low-side gate drive
);
  //--------------------------------------------------------------
  // Register storage
  //--------------------------------------------------------------
  reg  [5:0]  nvcfg_r;
  reg  [3:0]  tgt_addr_r;
  reg  [7:0]  boot_r;
  reg  [5:0]  slew_r;
  reg  [7:0]  wp_r [0:3];
  reg  [11:0] period_r;
  reg  [11:0] duty_r;
  reg  [7:0]  target_r;
  reg         slow_sel_r;
  reg  [16:0] acc_r;
  reg         ramping_r;
  reg         en_d_r;
  // A write lands only at the edge where the master samples ready high
  wire        wr_en = psel & penable & pwrite & pready;
  wire        rd_en = psel & penable & ~pwrite & ~pready;
  //--------------------------------------------------------------
  // Link input synchronisers and frame receiver
  //--------------------------------------------------------------
  reg  [2:0]  lclk_s_r;
  reg  [1:0]  ldat_s_r;
  reg  [4:0]  bit_cnt_r;
  reg  [15:0] shift_r;
  reg  [7:0]  idle_cnt_r;
  reg         frame_done_r;
  // Two flops before use; third stage only feeds the edge detector
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lclk_s_r <= 3'b000;
      ldat_s_r <= 2'b00;
    end else begin
      lclk_s_r <= {lclk_s_r[1:0], link_clk};
      ldat_s_r <= {ldat_s_r[0], link_data};
    end
  end
  wire lclk_rise = lclk_s_r[1] & ~lclk_s_r[2];
  // clock and data in
  // Start bit is a low sample, then 16 bits MSB first; an idle timeout resyncs the frame
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_r    <= 5'd0;
      shift_r      <= 16'h0000;
      idle_cnt_r   <= 8'h00;
      frame_done_r <= 1'b0;
    end else begin
      frame_done_r <= 1'b0;
      if (lclk_rise) begin
        idle_cnt_r <= 8'h00;
        if (bit_cnt_r == 5'd0) begin
          if (!ldat_s_r[1])
            bit_cnt_r <= 5'd1;
        end else begin
          shift_r <= {shift_r[14:0], ldat_s_r[1]};
          if (bit_cnt_r == `VLT_FRAME_BITS) begin
            bit_cnt_r    <= 5'd0;
            frame_done_r <= 1'b1;
          end else begin
            bit_cnt_r <= bit_cnt_r + 5'd1;
          end
        end
      end else if (idle_cnt_r == `VLT_LINK_TO) begin
        bit_cnt_r <= 5'd0;
      end else begin
        idle_cnt_r <= idle_cnt_r + 8'h01;
      end
    end
  end
  //--------------------------------------------------------------
  // Address decode
  //--------------------------------------------------------------
  wire [3:0] f_addr = shift_r[15:12];
  wire [3:0] f_cmd  = shift_r[11:8];
  wire [7:0] f_data = shift_r[7:0];
  wire [1:0] ac_cfg = nvcfg_r[`VLT_CFG_AC_HI:`VLT_CFG_AC_LO];
  // 0F for processor rail, 0E for memory rail
  wire bc_mem_ok = (ac_cfg == `VLT_AC_BOTH) | (ac_cfg == `VLT_AC_MEM);
  wire bc_cpu_ok = (ac_cfg == `VLT_AC_BOTH) | (ac_cfg == `VLT_AC_CPU);
  wire is_bc     = ((f_addr == `VLT_BC_MEM) & bc_mem_ok) | ((f_addr == `VLT_BC_CPU) & bc_cpu_ok);
  wire is_mine   = (f_addr == tgt_addr_r);
  wire accept    = frame_done_r & (is_mine | is_bc);
  //--------------------------------------------------------------
  // Mode, resolution and boot selection
  //--------------------------------------------------------------
  wire new_mode = nvcfg_r[`VLT_CFG_NEWMODE];
  // newer mode picks 5 or 10 mV
  wire res_5mv  = new_mode & nvcfg_r[`VLT_CFG_RES5];
  // older boot from register if set
  wire [7:0] boot_vid = (new_mode | nvcfg_r[`VLT_CFG_BOOTREG]) ? boot_r : 8'h00;
  wire en_rise = nvcfg_r[`VLT_CFG_EN] & ~en_d_r;
  //--------------------------------------------------------------
  // Slew rate: increment per cycle in 1/16 of half mV/us
  //--------------------------------------------------------------
  wire [3:0]  fast_idx = slew_r[3:0];
  wire [7:0]  rate_half = (fast_idx > `VLT_FAST_LAST) ? `VLT_RATE_MAX :
                          (8'd20 + {1'b0, fast_idx, 3'b000} + {3'b000, fast_idx, 1'b0});
  wire [11:0] rate_fx  = {rate_half, 4'h0};
  // slow = fast over 2, 4, 8, 16
  wire [2:0]  sh       = slow_sel_r ? ({1'b0, slew_r[5:4]} + 3'd1) : 3'd0;
  wire [11:0] inc      = rate_fx >> sh;
  wire [16:0] thr      = res_5mv ? `VLT_THR_5MV : `VLT_THR_10MV;
  wire [16:0] acc_sum  = acc_r + {5'b00000, inc};
  wire        step     = ramping_r & (acc_sum >= thr);
  //--------------------------------------------------------------
  // Target, ramp and alert
  //--------------------------------------------------------------
  // Ramp reaching the target raises alert; a new accepted frame clears it, set wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_r    <= 8'h00;
      slow_sel_r  <= 1'b0;
      power_state <= 2'b00;
      vid_ref     <= 8'h00;
      acc_r       <= 17'h00000;
      ramping_r   <= 1'b0;
      alert_n     <= 1'b1;
      en_d_r      <= 1'b0;
    end else begin
      en_d_r <= nvcfg_r[`VLT_CFG_EN];
      if (en_rise) begin
        target_r   <= boot_vid;
        slow_sel_r <= 1'b0;
      end else if (accept) begin
        case (f_cmd)
          `VLT_CMD_VFAST: begin
            target_r   <= f_data;
            slow_sel_r <= 1'b0;
          end
          `VLT_CMD_VSLOW: begin
            target_r   <= f_data;
            slow_sel_r <= 1'b1;
          end
          `VLT_CMD_SETWP: begin
            if (is_bc) begin
              target_r    <= wp_r[f_data[1:0]];
              slow_sel_r  <= 1'b0;
              power_state <= f_data[7:6];
            end
          end
          `VLT_CMD_SETPS: begin
            power_state <= f_data[1:0];
          end
          default: begin
            target_r <= target_r;
          end
        endcase
      end
      ramping_r <= (vid_ref != target_r);
      if (!ramping_r) begin
        acc_r <= 17'h00000;
      end else if (step) begin
        acc_r   <= acc_sum - thr;
        vid_ref <= (target_r > vid_ref) ? vid_ref + 8'h01 : vid_ref - 8'h01;
      end else begin
        acc_r <= acc_sum;
      end
      if (step && ((vid_ref + 8'h01 == target_r) || (vid_ref - 8'h01 == target_r)))
        alert_n <= 1'b0;
      else if (accept)
        alert_n <= 1'b1;
    end
  end
  //--------------------------------------------------------------
  // PWM cycle counter and duty limiter
  //--------------------------------------------------------------
  reg  [11:0] pwm_cnt_r;
  reg  [11:0] per_sh_r;
  reg  [11:0] duty_sh_r;
  wire        wrap_w   = (pwm_cnt_r + 12'h001 >= per_sh_r);
  wire [11:0] cnt_nxt  = wrap_w ? 12'h000 : pwm_cnt_r + 12'h001;
  // Settings apply only from a cycle start, so a write never cuts the off time short
  wire [11:0] per_use  = wrap_w ? period_r : per_sh_r;
  wire [11:0] duty_use = wrap_w ? duty_r : duty_sh_r;
  wire [11:0] blank_w  = {3'b000, per_use[11:3]};
  wire [11:0] guard_w  = (blank_w > `VLT_OFF_MIN) ? blank_w : `VLT_OFF_MIN;
  wire [11:0] lim_w    = (per_use > guard_w) ? (per_use - guard_w) : 12'h000;
  wire [11:0] duty_eff = (duty_use < lim_w) ? duty_use : lim_w;
  wire [11:0] on_start = per_use - duty_eff;
  // On-time sits at the end of the cycle, so the blank and off time lead each cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_cnt_r         <= 12'h000;
      per_sh_r          <= `VLT_RST_PERIOD;
      duty_sh_r         <= `VLT_RST_DUTY;
      cycle_blank_pulse <= 1'b0;
      high_side_switch  <= 1'b0;
      low_side_switch   <= 1'b0;
    end else begin
      pwm_cnt_r <= cnt_nxt;
      if (wrap_w) begin
        per_sh_r  <= period_r;
        duty_sh_r <= duty_r;
      end
      cycle_blank_pulse <= (cnt_nxt < blank_w);
      high_side_switch  <= (duty_eff != 12'h000) & (cnt_nxt >= on_start);
      low_side_switch   <= ~((duty_eff != 12'h000) & (cnt_nxt >= on_start));
    end
  end
  //--------------------------------------------------------------
  // APB slave: one wait state, ready and data registered
  //--------------------------------------------------------------
  reg [31:0] rd_mux;
  reg        rd_hit;
  always @* begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `VLT_OFF_CFG:    rd_mux = {26'h000_0000, nvcfg_r};
      `VLT_OFF_ADDR:   rd_mux = {28'h000_0000, tgt_addr_r};
      `VLT_OFF_BOOT:   rd_mux = {24'h00_0000, boot_r};
      `VLT_OFF_SLEW:   rd_mux = {26'h000_0000, slew_r};
      `VLT_OFF_WP0:    rd_mux = {24'h00_0000, wp_r[0]};
      `VLT_OFF_WP1:    rd_mux = {24'h00_0000, wp_r[1]};
      `VLT_OFF_WP2:    rd_mux = {24'h00_0000, wp_r[2]};
      `VLT_OFF_WP3:    rd_mux = {24'h00_0000, wp_r[3]};
      `VLT_OFF_PERIOD: rd_mux = {20'h0_0000, period_r};
      `VLT_OFF_DUTY:   rd_mux = {20'h0_0000, duty_r};
      `VLT_OFF_STATUS: rd_mux = {11'h000, ~alert_n, slow_sel_r, ramping_r, power_state,
                                 target_r, vid_ref};
      default:         rd_hit = 1'b0;
    endcase
  end
  // Writes land at the ready edge; status is read-only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h0000_0000;
      nvcfg_r    <= `VLT_RST_CFG;
      tgt_addr_r <= `VLT_RST_ADDR;
      boot_r     <= `VLT_RST_BOOT;
      slew_r     <= `VLT_RST_SLEW;
      period_r   <= `VLT_RST_PERIOD;
      duty_r     <= `VLT_RST_DUTY;
      wp_r[0]    <= 8'h00;
      wp_r[1]    <= 8'h00;
      wp_r[2]    <= 8'h00;
      wp_r[3]    <= 8'h00;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~(rd_hit & ~(pwrite & (paddr == `VLT_OFF_STATUS)));
      if (rd_en)
        prdata <= rd_hit ? rd_mux : 32'h0000_0000;
      if (wr_en) begin
        case (paddr)
          `VLT_OFF_CFG:    nvcfg_r    <= pwdata[5:0];
          `VLT_OFF_ADDR:   tgt_addr_r <= pwdata[3:0];
          `VLT_OFF_BOOT:   boot_r     <= pwdata[7:0];
          `VLT_OFF_SLEW:   slew_r     <= pwdata[5:0];
          `VLT_OFF_WP0:    wp_r[0]    <= pwdata[7:0];
          `VLT_OFF_WP1:    wp_r[1]    <= pwdata[7:0];
          `VLT_OFF_WP2:    wp_r[2]    <= pwdata[7:0];
          `VLT_OFF_WP3:    wp_r[3]    <= pwdata[7:0];
          `VLT_OFF_PERIOD: period_r   <= pwdata[11:0];
          `VLT_OFF_DUTY:   duty_r     <= pwdata[11:0];
          default:         boot_r     <= boot_r;
        endcase
      end
    end
  end
endmodule // vlt_ctrl
`default_nettype wire

/* pkg/vlt_regs.vh */
// Register offsets, field positions, reset values and timing counts for the VID link control
`ifndef VLT_REGS_VH
`define VLT_REGS_VH
// Register byte offsets
`define VLT_OFF_CFG      12'h000
`define VLT_OFF_ADDR     12'h004
`define VLT_OFF_BOOT     12'h008
`define VLT_OFF_SLEW     12'h00C
`define VLT_OFF_WP0      12'h010
`define VLT_OFF_WP1      12'h014
`define VLT_OFF_WP2      12'h018
`define VLT_OFF_WP3      12'h01C
`define VLT_OFF_PERIOD   12'h020
`define VLT_OFF_DUTY     12'h024
`define VLT_OFF_STATUS   12'h028
// Configuration word fields
`define VLT_CFG_EN       0
`define VLT_CFG_NEWMODE  1
`define VLT_CFG_RES5     2
`define VLT_CFG_BOOTREG  3
`define VLT_CFG_AC_LO    4
`define VLT_CFG_AC_HI    5
// Reset values
`define VLT_RST_CFG      6'h00
`define VLT_RST_ADDR     4'h2
`define VLT_RST_BOOT     8'h00
`define VLT_RST_SLEW     6'h00
`define VLT_RST_PERIOD   12'h080
`define VLT_RST_DUTY     12'h040
// Broadcast addresses and broadcast option codes
`define VLT_BC_MEM       4'hE
`define VLT_BC_CPU       4'hF
`define VLT_AC_BOTH      2'h0
`define VLT_AC_MEM       2'h1
`define VLT_AC_CPU       2'h2
// Frame commands
`define VLT_CMD_VFAST    4'h1
`define VLT_CMD_VSLOW    4'h2
`define VLT_CMD_SETWP    4'h3
`define VLT_CMD_SETPS    4'h4
`define VLT_FRAME_BITS   5'd16
// Timing: link idle timeout in cycles, fixed PWM off time in cycles
`define VLT_LINK_TO      8'h40
`define VLT_OFF_MIN      12'h00A
// Step thresholds: step_mV * 125 cycles/us * 2 (half mV/us) * 16 (fraction)
`define VLT_THR_5MV      17'h04E20
`define VLT_THR_10MV     17'h09C40
`define VLT_FAST_LAST    4'hC
`define VLT_RATE_MAX     8'hA0
`endif

/* tb/testbench.sv */
// Self-checking bench for the VID link control
`timescale 1ns/1ns
`default_nettype none
`include "vlt_regs.vh"
`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin fails++; \
  $display("wrong value at %0t: got %0h want %0h", $time, g, x); end end
module testbench;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, r;
  logic [7:0]  wp [4];
  logic [7:0]  t;
  wire  [31:0] prdata;
  wire  [7:0]  vid_ref;
  wire  [1:0]  power_state;
  wire         pready, pslverr, link_clk, link_data, alert_n;
  wire         cycle_blank_pulse, high_side_switch, low_side_switch;
  integer      fails = 0, comparisons = 0, cyc = 0, seed = 32'hbf5e, n, i, j, k, ps, p, d;
  vlt_ctrl u_vlt_ctrl (
    .pclk              (pclk),
    .presetn           (presetn),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .link_clk          (link_clk),
    .link_data         (link_data),
    .alert_n           (alert_n),
    .vid_ref           (vid_ref),
    .power_state       (power_state),
    .cycle_blank_pulse (cycle_blank_pulse),
    .high_side_switch  (high_side_switch),
    .low_side_switch   (low_side_switch)
  );
  vlt_link_host u_vlt_link_host (
    .link_clk  (link_clk),
    .link_data (link_data)
  );
  // ----
  // Clock, timeout and verdict
  // ----
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 90000) begin
      fails = fails + 1;
      stop_test();
    end
  end
  task stop_test;
    begin
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // APB transfer held until ready is sampled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    begin
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
      @(posedge pclk);
      penable <= 1'b1;
      // No cycle count assumed; a hung slave is ended by the bench timeout
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
    end
  endtask
  task frm(input logic [3:0] a, input logic [3:0] c, input logic [7:0] x);
    begin
      u_vlt_link_host.send(a, c, x);
      repeat (8) @(posedge pclk);
    end
  endtask
  task tgt(input logic [7:0] x);
    begin
      apb(1'b0, `VLT_OFF_STATUS, 32'h0000_0000);
      `CHK(r[15:8], x)
    end
  endtask
  task settle(input logic [7:0] x);
    begin
      for (n = 0; vid_ref !== x && n < 9000; n++) @(posedge pclk);
      `CHK(vid_ref, x)
    end
  endtask
  // Four-code ramp timed until alert falls; frame latency is in the margin
  task ramp(input logic [3:0] c, input integer x);
    begin
      t = t ^ 8'h04;
      frm(4'h2, c, t);
      for (n = 0; alert_n !== 1'b0 && n < 9000; n++) @(posedge pclk);
      `CHK(n + 24 > x && n < x + x / 8 + 24, 1'b1)
      `CHK(vid_ref, t)
    end
  endtask
  function integer rate_h(input integer f);
    rate_h = (f > 12) ? 160 : 20 + 10 * f;
  endfunction
  function integer onmax(input integer pp, input integer dd);
    onmax = (pp / 8 > 10) ? pp - pp / 8 : pp - 10;
    if (dd < onmax) onmax = dd;
  endfunction
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `VLT_OFF_ADDR, 32'h0000_0000);
    `CHK(r, 32'h0000_0002)
    apb(1'b0, 12'h02C, 32'h0000_0000);
    `CHK(e, 1'b1)
    apb(1'b1, `VLT_OFF_STATUS, 32'h0000_00FF);
    `CHK(e, 1'b1)
    apb(1'b1, `VLT_OFF_SLEW, 32'h0000_000C);
    apb(1'b1, `VLT_OFF_BOOT, 32'h0000_0020);
    apb(1'b1, `VLT_OFF_CFG, 32'h0000_0009);
    tgt(8'h20);
    settle(8'h20);
    apb(1'b1, `VLT_OFF_CFG, 32'h0000_0000);
    apb(1'b1, `VLT_OFF_CFG, 32'h0000_0001);
    tgt(8'h00);
    settle(8'h00);
    apb(1'b1, `VLT_OFF_CFG, 32'h0000_0000);
    apb(1'b1, `VLT_OFF_CFG, 32'h0000_0007);
    tgt(8'h20);
    frm(4'h5, `VLT_CMD_VFAST, 8'h30);
    tgt(8'h20);
    apb(1'b1, `VLT_OFF_ADDR, 32'h0000_0007);
    frm(4'h2, `VLT_CMD_VFAST, 8'h30);
    tgt(8'h20);
    frm(4'h7, `VLT_CMD_VFAST, 8'h24);
    tgt(8'h24);
    apb(1'b1, `VLT_OFF_ADDR, 32'h0000_0002);
    t = 8'h24;
    for (k = 0; k < 4; k++) begin
      wp[k] = 8'($random(seed));
      apb(1'b1, `VLT_OFF_WP0 + 12'(4 * k), {24'h00_0000, wp[k]});
    end
    // Every broadcast option against both broadcast addresses
    for (i = 0; i < 4; i++) begin
      apb(1'b1, `VLT_OFF_CFG, 32'h0000_0007 | (i << 4));
      for (j = 0; j < 2; j++) begin
        k = $random(seed) & 3;
        ps = $random(seed) & 3;
        frm(j ? `VLT_BC_CPU : `VLT_BC_MEM, `VLT_CMD_SETWP, {2'(ps), 4'h0, 2'(k)});
        if (i == 0 || i == j + 1) begin
          t = wp[k];
          `CHK(power_state, 2'(ps))
        end
        tgt(t);
      end
    end
    frm(4'h2, `VLT_CMD_SETWP, 8'h01);
    tgt(t);
    frm(4'h2, `VLT_CMD_SETPS, 8'h02);
    `CHK(power_state, 2'h2)
    apb(1'b1, `VLT_OFF_CFG, 32'h0000_0007);
    settle(t);
    for (i = 0; i < 16; i++) begin
      apb(1'b1, `VLT_OFF_SLEW, i);
      ramp(`VLT_CMD_VFAST, 5000 / rate_h(i));
    end
    for (i = 0; i < 4; i++) begin
      apb(1'b1, `VLT_OFF_SLEW, (i << 4) | 12);
      ramp(`VLT_CMD_VSLOW, 5000 * (2 << i) / 140);
    end
    // 10 mV steps: newer mode without the 5 mV bit, older mode ignoring it
    apb(1'b1, `VLT_OFF_SLEW, 32'h0000_0000);
    for (i = 0; i < 2; i++) begin
      apb(1'b1, `VLT_OFF_CFG, i ? 32'h0000_0005 : 32'h0000_0003);
      ramp(`VLT_CMD_VFAST, 10000 / rate_h(0));
    end
    // Duty limit: blank dominated, fixed off dominated, random duty
    for (i = 0; i < 3; i++) begin
      p = (i == 1) ? 64 : 128;
      d = (i == 2) ? (($random(seed) & 127) | 1) : 4095;
      apb(1'b1, `VLT_OFF_PERIOD, p);
      apb(1'b1, `VLT_OFF_DUTY, d);
      repeat (300) @(posedge pclk);
      for (n = 0; high_side_switch !== 1'b0 && n < 600; n++) @(posedge pclk);
      for (n = 0; high_side_switch !== 1'b1 && n < 600; n++) @(posedge pclk);
      for (k = 0; high_side_switch === 1'b1 && k < 600; k++) @(posedge pclk);
      `CHK(k, onmax(p, d))
    end
    stop_test();
  end
endmodule // testbench
`default_nettype wire

/* tb/vlt_ctrl_monitor.sv */
// Port checker for the VID link control
`timescale 1ns/1ns
`default_nettype none
module vlt_ctrl_monitor (
  input wire logic       pclk,              // System clock
  input wire logic       presetn,           // Reset, active low
  input wire logic       psel,              // APB select
  input wire logic       penable,           // APB access
  input wire logic       pready,            // APB ready
  input wire logic       pslverr,           // APB error
  input wire logic       alert_n,           // Alert, active low
  input wire logic [7:0] vid_ref,           // Reference code
  input wire logic       cycle_blank_pulse, // Cycle blank
  input wire logic       high_side_switch,  // High-side drive
  input wire logic       low_side_switch    // Low-side drive
);
  logic [11:0] cnt_r;
  logic [11:0] len_r;
  logic [11:0] bl_r;
  logic        bq_r;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Period and blank width; two equal periods needed so a period write is not judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {cnt_r, len_r, bl_r, bq_r} <= '0;
    end else begin
      bq_r <= cycle_blank_pulse;
      cnt_r <= (cycle_blank_pulse && !bq_r) ? 12'h001 : cnt_r + 12'h001;
      if (cycle_blank_pulse && !bq_r) len_r <= cnt_r;
      if (bq_r && !cycle_blank_pulse) bl_r <= cnt_r;
    end
  end
  property p_blank_w;
    (cycle_blank_pulse && !bq_r && len_r == cnt_r && len_r != 12'h000) |-> bl_r == (cnt_r >> 3);
  endproperty
  a_blank_w: assert property (p_blank_w) else $error("blank width wrong");
  property p_blank_hs;
    cycle_blank_pulse |-> !high_side_switch;
  endproperty
  a_blank_hs: assert property (p_blank_hs) else $error("drive during blank");
  property p_comp;
    high_side_switch |-> !low_side_switch;
  endproperty
  a_comp: assert property (p_comp) else $error("both switches on");
  property p_offtime;
    $rose(high_side_switch) |-> $past(low_side_switch, 10);
  endproperty
  a_offtime: assert property (p_offtime) else $error("off time short");
  property p_step;
    $changed(vid_ref) |-> (vid_ref - $past(vid_ref) == 8'h01 || $past(vid_ref) - vid_ref == 8'h01);
  endproperty
  a_step: assert property (p_step) else $error("reference jumped");
  property p_ramp_alert;
    $fell(alert_n) |-> $changed(vid_ref);
  endproperty
  a_ramp_alert: assert property (p_ramp_alert) else $error("alert without arrival");
  property p_alert_hold;
    $fell(alert_n) |=> $stable(vid_ref) [*2];
  endproperty
  a_alert_hold: assert property (p_alert_hold) else $error("moved after alert");
  property p_rdy;
    (psel && penable && !pready) |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  property p_rdy_one;
    pready |=> !pready;
  endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("ready too long");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  c_alert: cover property ($fell(alert_n));
  c_err: cover property (pslverr);
  c_hs: cover property ($rose(high_side_switch));
endmodule // vlt_ctrl_monitor
bind vlt_ctrl vlt_ctrl_monitor u_vlt_ctrl_monitor (
  .pclk              (pclk),
  .presetn           (presetn),
  .psel              (psel),
  .penable           (penable),
  .pready            (pready),
  .pslverr           (pslverr),
  .alert_n           (alert_n),
  .vid_ref           (vid_ref),
  .cycle_blank_pulse (cycle_blank_pulse),
  .high_side_switch  (high_side_switch),
  .low_side_switch   (low_side_switch)
);
`default_nettype wire

/* tb/vlt_link_host.sv */
// Host model driving the link clock and data
`timescale 1ns/1ns
`default_nettype none
module vlt_link_host (
  output var logic link_clk,  // Link clock, still between frames
  output var logic link_data  // Link data, idle high
);
  integer nf = 0;
  initial begin
    link_clk = 1'b0;
    link_data = 1'b1;
  end
  // start bit, address, command, data MSB first
  task automatic send(input logic [3:0] a, input logic [3:0] c, input logic [7:0] d);
    logic [16:0] f;
    begin
      f = {1'b0, a, c, d};
      nf = nf + 1;
      // Shifting start keeps link edges off the system clock edges
      #(1 + nf % 5);
      for (int i = 16; i >= 0; i--) begin
        link_data = f[i];
        #32 link_clk = 1'b1;
        #32 link_clk = 1'b0;
      end
      link_data = 1'b1;
      #96;
    end
  endtask
endmodule // vlt_link_host
`default_nettype wire
